// ===== core/cpu_stack_timing_priority.sv
/*
  core support logic: instruction cycle timer, external-data move routing,
  stack pointer with stack memory sequencing, stack record and extended
  interrupt priority register on the special-function register port.
  assumes the core decoder gives one request at a time on each group, holds
  no request while the matching busy output is high, and that internal data
  memory takes one write or read address per cycle from this block.
*/
`timescale 1ns/1ps

module cpu_stack_timing_priority
  import cpu_support_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,

  // special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,

  // instruction timing requests from the decoder
  input wire logic instr_valid,
  input wire logic [3:0] instr_bytes,
  input wire logic [3:0] instr_clocks,
  input wire logic instr_use_bytes,
  input wire logic instr_cond,
  input wire logic instr_taken,
  output logic instr_busy,
  output logic instr_done,

  // external-data move requests
  input wire logic program_store_control,
  input wire logic movx_req,
  input wire logic movx_write,
  input wire logic [15:0] movx_addr,
  input wire logic [7:0] movx_wdata,
  output logic xdata_req,
  output logic prog_req,
  output logic mem_write,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,

  // stack operations from the core
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic stk_inc,
  input wire logic stk_dec,
  input wire logic stk_call,
  input wire logic stk_ret,
  input wire logic [7:0] stk_wdata,
  input wire logic [15:0] stk_pc,
  output logic stk_busy,

  // internal data memory port for stack traffic
  output logic iram_wr,
  output logic iram_rd,
  output logic [7:0] iram_addr,
  output logic [7:0] iram_wdata,

  // stack pointer and stack record toward debug
  output logic [7:0] stack_pointer,
  output logic [record_width-1:0] stack_record_bits,
  output logic [5:0] stack_record_depth,
  output logic stack_overflow,
  output logic stack_underflow,

  // interrupt priority levels, one means high
  output logic crystal_valid_irq_priority,
  output logic ext_irq_seven_priority,
  output logic ext_irq_six_priority,
  output logic ext_irq_five_priority,
  output logic ext_irq_four_priority,
  output logic converter_eoc_priority,
  output logic timer_three_priority
);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // execution length in clock cycles, never below one
  function automatic logic [3:0] exec_cycles(input logic [3:0] bytes, input logic [3:0] clocks,
                                             input logic use_bytes, input logic cond,
                                             input logic taken);
    logic [3:0] n;
    n = 4'h0;
    // pipelined fetch makes most instructions cost one cycle per byte
    n = use_bytes ? bytes : clocks;
    // failed condition skips the branch target fetch
    if (cond && !taken && n > min_exec_cycles) begin
      n = n - min_exec_cycles;
    end
    if (n < min_exec_cycles) begin
      n = min_exec_cycles;
    end
    return n;
  endfunction

  // address match on the register port
  function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a == reg_addr;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************

  // all state of this module in one struct; record and priority state sit in the sub-blocks
  typedef struct packed {
    exec_state_type exec_state;
    logic [3:0] exec_count;
    logic instr_done;
    logic xdata_req;
    logic prog_req;
    logic mem_write;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    stack_state_type stk_state;
    logic [7:0] sp;
    logic [7:0] pc_high;
    logic iram_wr;
    logic iram_rd;
    logic [7:0] iram_addr;
    logic [7:0] iram_wdata;
    logic [7:0] sfr_rdata;
    logic sfr_rvalid;
  } top_state_type;

  top_state_type cur; // registered state
  top_state_type next_cur; // next state

  logic [7:0] priority_value; // extended priority register value
  logic priority_wr; // write strobe toward the priority register
  logic [1:0] rec_push_bits; // record bits pushed this cycle
  logic [1:0] rec_pop_bits; // record bits popped this cycle
  logic rec_push_value; // one marks a call frame, zero a data push
  logic stack_idle; // no multi-cycle stack sequence under way

  assign stack_idle = cur.stk_state == stk_idle;

  // ****************************************************************
  // register decode
  // ****************************************************************

  // priority register written only on an exact address match
  assign priority_wr = sfr_wr && sfr_hit(sfr_addr, addr_extended_irq_priority_two);

  // ****************************************************************
  // stack record request decode
  // ****************************************************************

  // record follows each stack event as it is accepted
  always_comb begin
    rec_push_bits = record_none;
    rec_pop_bits = record_none;
    rec_push_value = 1'b0;
    if (stack_idle) begin
      if (stk_call) begin
        // call or interrupt entry leaves two bits
        rec_push_bits = record_two;
        rec_push_value = 1'b1;
      end else if (stk_push || stk_inc) begin
        // push or pointer increment leaves one bit
        rec_push_bits = record_one;
      end else if (stk_ret) begin
        // return takes two bits back
        rec_pop_bits = record_two;
      end else if (stk_pop || stk_dec) begin
        // pop or pointer decrement takes one
        rec_pop_bits = record_one;
      end
    end
  end

  // ****************************************************************
  // next-state logic
  // ****************************************************************

  // one combinational pass covers timer, move routing, stack and register reads
  always_comb begin
    next_cur = cur;
    next_cur.instr_done = 1'b0;
    next_cur.xdata_req = 1'b0;
    next_cur.prog_req = 1'b0;
    next_cur.iram_wr = 1'b0;
    next_cur.iram_rd = 1'b0;
    next_cur.sfr_rvalid = 1'b0;

    // instruction timer counts raw clocks, no machine-cycle grouping
    case (cur.exec_state)
      exec_idle: begin
        if (instr_valid) begin
          // opcode semantics stay with the core; only length is timed here
          next_cur.exec_count = exec_cycles(instr_bytes, instr_clocks, instr_use_bytes,
                                            instr_cond, instr_taken);
          if (next_cur.exec_count == min_exec_cycles) begin
            next_cur.instr_done = 1'b1;
          end else begin
            next_cur.exec_state = exec_run;
          end
        end
      end
      exec_run: begin
        // last cycle of the instruction ends the count
        if (cur.exec_count == 4'h2) begin
          next_cur.instr_done = 1'b1;
          next_cur.exec_state = exec_idle;
        end
        next_cur.exec_count = cur.exec_count - 4'h1;
      end
      default: begin
        next_cur.exec_state = exec_idle;
      end
    endcase

    // external-data move goes to flash when program store is selected
    if (movx_req) begin
      next_cur.xdata_req = !program_store_control;
      next_cur.prog_req = program_store_control;
      next_cur.mem_write = movx_write;
      next_cur.mem_addr = movx_addr;
      next_cur.mem_wdata = movx_wdata;
    end

    // stack sequencer; the 8-bit pointer wraps so any of 256 bytes serves
    case (cur.stk_state)
      stk_idle: begin
        if (stk_call) begin
          // low byte of the return address goes one above the pointer
          next_cur.iram_wr = 1'b1;
          next_cur.iram_addr = cur.sp + 8'h01;
          next_cur.iram_wdata = stk_pc[7:0];
          next_cur.pc_high = stk_pc[15:8];
          next_cur.sp = cur.sp + 8'h01;
          next_cur.stk_state = stk_call_high;
        end else if (stk_push) begin
          // write above the pointer, pointer then marks it used
          next_cur.iram_wr = 1'b1;
          next_cur.iram_addr = cur.sp + 8'h01;
          next_cur.iram_wdata = stk_wdata;
          next_cur.sp = cur.sp + 8'h01;
        end else if (stk_inc) begin
          next_cur.sp = cur.sp + 8'h01;
        end else if (stk_ret) begin
          // high byte sits at the pointer, read it first
          next_cur.iram_rd = 1'b1;
          next_cur.iram_addr = cur.sp;
          next_cur.sp = cur.sp - 8'h01;
          next_cur.stk_state = stk_ret_low;
        end else if (stk_pop) begin
          // pointer names the last used byte, so read there
          next_cur.iram_rd = 1'b1;
          next_cur.iram_addr = cur.sp;
          next_cur.sp = cur.sp - 8'h01;
        end else if (stk_dec) begin
          next_cur.sp = cur.sp - 8'h01;
        end
      end
      stk_call_high: begin
        // second frame byte completes the call
        next_cur.iram_wr = 1'b1;
        next_cur.iram_addr = cur.sp + 8'h01;
        next_cur.iram_wdata = cur.pc_high;
        next_cur.sp = cur.sp + 8'h01;
        next_cur.stk_state = stk_idle;
      end
      stk_ret_low: begin
        next_cur.iram_rd = 1'b1;
        next_cur.iram_addr = cur.sp;
        next_cur.sp = cur.sp - 8'h01;
        next_cur.stk_state = stk_idle;
      end
      default: begin
        next_cur.stk_state = stk_idle;
      end
    endcase

    // software write to the pointer wins over a stack step in the same cycle
    if (sfr_wr && sfr_hit(sfr_addr, addr_stack_pointer)) begin
      next_cur.sp = sfr_wdata;
    end

    // register reads answer one cycle later; unmapped addresses read zero
    if (sfr_rd) begin
      next_cur.sfr_rvalid = 1'b1;
      if (sfr_hit(sfr_addr, addr_stack_pointer)) begin
        next_cur.sfr_rdata = cur.sp;
      end else if (sfr_hit(sfr_addr, addr_extended_irq_priority_two)) begin
        next_cur.sfr_rdata = priority_value;
      end else begin
        next_cur.sfr_rdata = sfr_read_default;
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // every reset puts the pointer just below register bank one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
      cur.exec_state <= exec_idle;
      cur.stk_state <= stk_idle;
      cur.sp <= reset_stack_pointer;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // sub-blocks
  // ****************************************************************

  // shift register view of the call stack for the debugger
  stack_record u_record (
    .clk(clk),
    .rst_n(rst_n),
    .push_bits(rec_push_bits),
    .pop_bits(rec_pop_bits),
    .push_value(rec_push_value),
    .record(stack_record_bits),
    .depth(stack_record_depth),
    .overflow(stack_overflow),
    .underflow(stack_underflow)
  );

  // priority levels for the extended interrupt sources
  irq_priority_reg u_priority (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(priority_wr),
    .wdata(sfr_wdata),
    .value(priority_value),
    .crystal_valid_irq_priority(crystal_valid_irq_priority),
    .ext_irq_seven_priority(ext_irq_seven_priority),
    .ext_irq_six_priority(ext_irq_six_priority),
    .ext_irq_five_priority(ext_irq_five_priority),
    .ext_irq_four_priority(ext_irq_four_priority),
    .converter_eoc_priority(converter_eoc_priority),
    .timer_three_priority(timer_three_priority)
  );

  // ****************************************************************
  // outputs, all from flip-flops
  // ****************************************************************

  assign sfr_rdata = cur.sfr_rdata;
  assign sfr_rvalid = cur.sfr_rvalid;
  assign instr_busy = cur.exec_state[0]; // low state bit is set only while running
  assign instr_done = cur.instr_done;
  assign xdata_req = cur.xdata_req;
  assign prog_req = cur.prog_req;
  assign mem_write = cur.mem_write;
  assign mem_addr = cur.mem_addr;
  assign mem_wdata = cur.mem_wdata;
  assign stk_busy = cur.stk_state[0]; // both sequence states carry the low bit
  assign iram_wr = cur.iram_wr;
  assign iram_rd = cur.iram_rd;
  assign iram_addr = cur.iram_addr;
  assign iram_wdata = cur.iram_wdata;
  assign stack_pointer = cur.sp;

endmodule

// ===== core/cpu_support_pkg.sv
/*
  shared constants and types for the core support block: special-function
  register addresses, reset values, field positions and state encodings.
  assumes nothing of its surroundings; imported whole by every design module.
*/
package cpu_support_pkg;

  // ****************************************************************
  // special-function register map
  // ****************************************************************
  localparam logic [7:0] addr_stack_pointer = 8'h81;
  localparam logic [7:0] addr_extended_irq_priority_two = 8'hf7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] reset_stack_pointer = 8'h07;
  localparam logic [7:0] reset_extended_irq_priority_two = 8'h00;
  localparam logic [7:0] sfr_read_default = 8'h00;

  // ****************************************************************
  // extended priority register field positions
  // ****************************************************************
  localparam int pos_crystal_valid_priority = 7;
  localparam int pos_reserved_six = 6;
  localparam int pos_ext_irq_seven_priority = 5;
  localparam int pos_ext_irq_six_priority = 4;
  localparam int pos_ext_irq_five_priority = 3;
  localparam int pos_ext_irq_four_priority = 2;
  localparam int pos_converter_eoc_priority = 1;
  localparam int pos_timer_three_priority = 0;
  localparam logic [7:0] priority_write_mask = 8'hbf;

  // ****************************************************************
  // stack record sizing and timing counts
  // ****************************************************************
  localparam int record_width = 32;
  localparam logic [5:0] record_full = 6'h20;
  localparam logic [3:0] min_exec_cycles = 4'h1;
  localparam logic [1:0] record_none = 2'h0;
  localparam logic [1:0] record_one = 2'h1;
  localparam logic [1:0] record_two = 2'h2;

  // ****************************************************************
  // state encodings, gray except the two-bit step between stk_idle and stk_ret_low
  // ****************************************************************
  typedef enum logic [1:0] {
    exec_idle = 2'b00,
    exec_run = 2'b01
  } exec_state_type;

  typedef enum logic [1:0] {
    stk_idle = 2'b00,
    stk_call_high = 2'b01,
    stk_ret_low = 2'b11
  } stack_state_type;

endpackage

// ===== core/stack_record.sv
/*
  32-bit stack record shift register with overflow and underflow detection.
  assumes the core asks for at most one push amount or one pop amount per cycle.
*/
`timescale 1ns/1ps
module stack_record
  import cpu_support_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // record requests: number of bits pushed or popped this cycle
  input wire logic [1:0] push_bits,
  input wire logic [1:0] pop_bits,
  input wire logic push_value,
  // record state toward debug
  output logic [record_width-1:0] record,
  output logic [5:0] depth,
  output logic overflow,
  output logic underflow
);

  // all state of the record in one struct
  typedef struct packed {
    logic [record_width-1:0] record;
    logic [5:0] depth;
    logic overflow;
    logic underflow;
  } rec_state_type;

  rec_state_type cur; // registered state
  rec_state_type next_cur; // next state

  // shift in or out, flag depth beyond either end
  always_comb begin
    next_cur = cur;
    next_cur.overflow = 1'b0;
    next_cur.underflow = 1'b0;
    if (push_bits != record_none) begin
      // calls and interrupts bring two bits, pushes one
      if (push_bits == record_two) begin
        next_cur.record = {cur.record[record_width-3:0], push_value, push_value};
      end else begin
        next_cur.record = {cur.record[record_width-2:0], push_value};
      end
      // overflow once more bits are live than the record holds
      if ({4'h0, push_bits} + cur.depth > record_full) begin
        next_cur.overflow = 1'b1;
        next_cur.depth = record_full;
      end else begin
        next_cur.depth = cur.depth + {4'h0, push_bits};
      end
    end else if (pop_bits != record_none) begin
      // pops remove one bit, returns remove two
      if (pop_bits == record_two) begin
        next_cur.record = {2'b00, cur.record[record_width-1:2]};
      end else begin
        next_cur.record = {1'b0, cur.record[record_width-1:1]};
      end
      // underflow when more bits leave than were recorded
      if (cur.depth < {4'h0, pop_bits}) begin
        next_cur.underflow = 1'b1;
        next_cur.depth = 6'h00;
      end else begin
        next_cur.depth = cur.depth - {4'h0, pop_bits};
      end
    end
  end

  // register the state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign record = cur.record;
  assign depth = cur.depth;
  assign overflow = cur.overflow;
  assign underflow = cur.underflow;

endmodule

// ===== core/irq_priority_reg.sv
/*
  extended interrupt priority register with its individual priority bits.
  assumes the owner decodes the address and gives a one-cycle write strobe.
*/
`timescale 1ns/1ps
module irq_priority_reg
  import cpu_support_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port from the register decode
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  // register value and priority levels, one means high
  output logic [7:0] value,
  output logic crystal_valid_irq_priority,
  output logic ext_irq_seven_priority,
  output logic ext_irq_six_priority,
  output logic ext_irq_five_priority,
  output logic ext_irq_four_priority,
  output logic converter_eoc_priority,
  output logic timer_three_priority
);

  // all state in one struct
  typedef struct packed {
    logic [7:0] value;
  } prio_state_type;

  prio_state_type cur; // registered state
  prio_state_type next_cur; // next state

  // store written bits; reserved bit six is never stored so it reads zero
  always_comb begin
    next_cur = cur;
    if (wr_en) begin
      next_cur.value = wdata & priority_write_mask;
    end
  end

  // all sources start at low priority
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur.value <= reset_extended_irq_priority_two;
    end else begin
      cur <= next_cur;
    end
  end

  assign value = cur.value;
  assign crystal_valid_irq_priority = cur.value[pos_crystal_valid_priority];
  assign ext_irq_seven_priority = cur.value[pos_ext_irq_seven_priority];
  assign ext_irq_six_priority = cur.value[pos_ext_irq_six_priority];
  assign ext_irq_five_priority = cur.value[pos_ext_irq_five_priority];
  assign ext_irq_four_priority = cur.value[pos_ext_irq_four_priority];
  assign converter_eoc_priority = cur.value[pos_converter_eoc_priority];
  assign timer_three_priority = cur.value[pos_timer_three_priority];

endmodule

// ===== verif/cpu_stack_timing_priority_assertions.sv
/* checker for the core support block: sees only the top module's ports.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module cpu_stack_timing_priority_assertions (
  // strobes, levels and flags
  input wire logic clk, rst_n, sfr_wr, sfr_rd, sfr_rvalid, instr_valid, instr_busy, instr_done,
  input wire logic instr_use_bytes, instr_cond, movx_req, program_store_control, prog_req, xdata_req,
  input wire logic stk_push, stk_call, stk_busy, iram_wr, stack_overflow, crystal_valid_irq_priority,
  input wire logic ext_irq_seven_priority, ext_irq_six_priority, ext_irq_five_priority,
  input wire logic ext_irq_four_priority, converter_eoc_priority, timer_three_priority,
  // buses
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, stack_pointer, iram_addr,
  input wire logic [3:0] instr_bytes,
  input wire logic [5:0] stack_record_depth
);
  // priority levels packed in register order, reserved bit as zero
  logic [7:0] levels;
  assign levels = {crystal_valid_irq_priority, 1'b0, ext_irq_seven_priority, ext_irq_six_priority,
    ext_irq_five_priority, ext_irq_four_priority, converter_eoc_priority, timer_three_priority};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_valid_a: assert property (sfr_rd |=> sfr_rvalid) else $error("read valid missing");
  sp_reset_a: assert property ($rose(rst_n) |-> stack_pointer == 8'h07 && levels == 8'h00)
    else $error("reset values wrong");
  push_addr_a: assert property (stk_push && !stk_busy && !stk_call |=> iram_wr &&
    iram_addr == $past(stack_pointer) + 8'h01) else $error("push address wrong");
  prio_map_a: assert property (sfr_wr && sfr_addr == 8'hf7 |=> levels == ($past(sfr_wdata) & 8'hbf))
    else $error("priority levels wrong");
  rsvd_zero_a: assert property (sfr_rd && sfr_addr == 8'hf7 |=> !sfr_rdata[6]) else $error("bit six set");
  two_byte_a: assert property (instr_valid && !instr_busy && instr_use_bytes && !instr_cond &&
    instr_bytes == 4'h2 |=> instr_busy && !instr_done ##1 instr_done && !instr_busy) else $error("timing wrong");
  prog_route_a: assert property (movx_req |=> prog_req == $past(program_store_control) &&
    xdata_req != prog_req) else $error("move routed wrong");
  call_two_a: assert property (stk_call && !stk_busy |=> stk_busy && iram_wr ##1 !stk_busy && iram_wr)
    else $error("call sequence wrong");
  ovf_sat_a: assert property (stack_overflow |-> stack_record_depth == 6'h20) else $error("overflow depth");
  cover property (stack_overflow);
  cover property (prog_req);
  cover property (instr_done && instr_cond);
endmodule
bind cpu_stack_timing_priority cpu_stack_timing_priority_assertions u_cpu_stack_timing_priority_assertions (.*);

// ===== verif/test_cpu_stack_timing_priority.sv
/* self-checking bench for the core support block.
   assumes inputs change 1 ns after the rising edge. */
`timescale 1ns/1ps
module test_cpu_stack_timing_priority;
  import cpu_support_pkg::*;
  logic clk, rst_n, sfr_wr, sfr_rd, sfr_rvalid, instr_valid, instr_use_bytes, instr_cond, instr_taken;
  logic instr_busy, instr_done, program_store_control, movx_req, movx_write, xdata_req, prog_req, mem_write;
  logic stk_push, stk_pop, stk_inc, stk_dec, stk_call, stk_ret, stk_busy, iram_wr, iram_rd;
  logic stack_overflow, stack_underflow, crystal_valid_irq_priority, ext_irq_seven_priority;
  logic ext_irq_six_priority, ext_irq_five_priority, ext_irq_four_priority, converter_eoc_priority;
  logic timer_three_priority;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, movx_wdata, mem_wdata, stk_wdata, iram_addr, iram_wdata;
  logic [7:0] stack_pointer, prio;
  logic [3:0] instr_bytes, instr_clocks;
  logic [15:0] movx_addr, mem_addr, stk_pc;
  logic [31:0] stack_record_bits;
  logic [5:0] stack_record_depth;
  int fails, n_tests, ovf, unf;
  // register rows: address, written value, value read back
  typedef struct {logic [7:0] a, d, r;} row_type;
  // software keeps reserved bit six at zero in every priority write
  row_type rows[5] = '{'{8'h81, 8'h5a, 8'h5a}, '{8'hf7, 8'hbf, 8'hbf}, '{8'hf7, 8'h24, 8'h24},
    '{8'hf7, 8'h81, 8'h81}, '{8'h3c, 8'hff, 8'h00}};
  assign prio = {crystal_valid_irq_priority, 1'b0, ext_irq_seven_priority, ext_irq_six_priority,
    ext_irq_five_priority, ext_irq_four_priority, converter_eoc_priority, timer_three_priority};
  cpu_stack_timing_priority u_cpu_stack_timing_priority (.*);
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // pulse flags counted as they pass, so their exact cycle does not matter
  always @(posedge clk) begin
    ovf += int'(stack_overflow === 1'b1);
    unf += int'(stack_underflow === 1'b1);
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // an idle edge before each request keeps every strobe to one change per time step
  task automatic sfr(logic wr, logic [7:0] a, logic [7:0] d);
    tick();
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {wr, !wr, a, d};
    tick();
    {sfr_wr, sfr_rd} = 2'b00;
  endtask
  // k: 0 push, 1 pop, 2 inc, 3 dec, 4 call, 5 ret
  task automatic stk(int k);
    tick();
    {stk_ret, stk_call, stk_dec, stk_inc, stk_pop, stk_push} = 6'(1 << k);
    tick();
    {stk_ret, stk_call, stk_dec, stk_inc, stk_pop, stk_push} = 6'h00;
  endtask
  task automatic timing(logic [3:0] b, c, logic u, cd, tk, int n);
    int k;
    tick();
    {instr_bytes, instr_clocks, instr_use_bytes, instr_cond, instr_taken, instr_valid} = {b, c, u, cd, tk, 1'b1};
    tick();
    instr_valid = 0;
    k = 1;
    while (instr_done !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    chk("instr cycles", n, k);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 400 cycles
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, instr_valid, instr_bytes, instr_clocks, instr_use_bytes} = '0;
    {instr_cond, instr_taken, program_store_control, movx_req, movx_write, movx_addr, movx_wdata} = '0;
    {stk_push, stk_pop, stk_inc, stk_dec, stk_call, stk_ret, stk_wdata, stk_pc, rst_n} = '0;
    tick(2);
    rst_n = 1;
    chk("stack_pointer", 8'h07, stack_pointer);
    sfr(0, 8'hf7, 8'h00);
    chk("priority reset", 8'h00, sfr_rdata);
    foreach (rows[i]) begin
      sfr(1, rows[i].a, rows[i].d);
      sfr(0, rows[i].a, 8'h00);
      chk("sfr_rvalid", 1, sfr_rvalid);
      chk("sfr_rdata", rows[i].r, sfr_rdata);
      if (rows[i].a == 8'hf7) chk("priority", rows[i].r, prio);
    end
    // push across the top of data memory wraps to zero
    sfr(1, 8'h81, 8'hff);
    stk_wdata = 8'h3c;
    stk(0);
    chk("push", {8'h01, 8'h00, 8'h3c, 8'h00}, {7'h0, iram_wr, iram_addr, iram_wdata, stack_pointer});
    chk("depth", 1, stack_record_depth);
    stk(1);
    chk("pop", {8'h01, 8'h00, 8'hff}, {7'h0, iram_rd, iram_addr, stack_pointer});
    stk(1);
    tick();
    chk("underflow", 1, unf);
    stk(2);
    chk("inc", 8'hff, stack_pointer);
    stk(3);
    chk("dec", 8'hfe, stack_pointer);
    sfr(1, 8'h81, 8'h30);
    stk_pc = 16'hbeef;
    stk(4);
    chk("call low", {8'h31, 8'hef}, {iram_addr, iram_wdata});
    tick();
    chk("call high", {8'h32, 8'hbe, 8'h32}, {iram_addr, iram_wdata, stack_pointer});
    stk(5);
    tick(2);
    chk("ret", 8'h30, stack_pointer);
    repeat (17) begin
      stk(4);
      tick();
    end
    tick();
    chk("overflow", {8'h01, 8'h20}, {ovf[7:0], 2'b00, stack_record_depth});
    chk("record", 32'hffffffff, stack_record_bits);
    timing(4'h3, 4'h0, 1, 0, 0, 3);
    timing(4'h2, 4'h0, 1, 0, 0, 2);
    timing(4'h0, 4'h5, 0, 0, 0, 5);
    timing(4'h3, 4'h0, 1, 1, 1, 3);
    timing(4'h3, 4'h0, 1, 1, 0, 2);
    timing(4'h1, 4'h0, 1, 0, 0, 1);
    for (int p = 0; p < 2; p++) begin
      tick();
      {program_store_control, movx_req, movx_write, movx_addr, movx_wdata} = {p[0], 1'b1, p[0], 16'h1234, 8'ha5};
      tick();
      movx_req = 0;
      chk("move route", {p[0], !p[0], p[0], 16'h1234}, {prog_req, xdata_req, mem_write, mem_addr});
      chk("move data", 8'ha5, mem_wdata);
    end
    rst_n = 0;
    tick(2);
    rst_n = 1;
    chk("second reset", {8'h07, 8'h00}, {stack_pointer, 2'b00, stack_record_depth});
    summarize();
  end
endmodule
